// ==== sim/simc_host_model.sv ====
`timescale 1ns/100ps
module simc_host_model import simc_pkg::*; (
   // clock
   input  wire logic     sys_clk_i,
   // serial pins
   input  wire logic     dout_i,
   output simc_spi_in_t  spi_o
);
   initial spi_o = '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
   // sample well clear of the synchroniser lag on both sides
   task automatic xfer(input int n, input logic [55:0] tx, output logic [55:0] rx, output logic tail);
      rx = '0;
      @(posedge sys_clk_i) spi_o.cs_n <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      for (int i = n - 1; i >= 0; i--) begin
         spi_o.sclk <= 1'b0;
         spi_o.din  <= tx[i];
         repeat (4) @(posedge sys_clk_i);
         spi_o.sclk <= 1'b1;
         repeat (2) @(posedge sys_clk_i);
         rx[i] = dout_i;
         repeat (2) @(posedge sys_clk_i);
      end
      repeat (8) @(posedge sys_clk_i);
      tail = dout_i;
      spi_o.cs_n <= 1'b1;
      spi_o.din  <= ~spi_o.din;
      repeat (8) @(posedge sys_clk_i);
   endtask : xfer
endmodule : simc_host_model

// ==== sim/simc_ifopt_sva.sv ====
`timescale 1ns/100ps
module simc_ifopt_sva import simc_pkg::*; (
   // clock and reset
   input wire logic                                  sys_clk_i,
   input wire logic                                  rst_i,
   // watched ports
   input wire simc_spi_in_t                          spi_i,
   input wire logic                                  spi_dout_oe_o,
   input wire logic [MON_WORDS-1:0][MON_WIDTH-1:0]   mon_regs_i,
   input wire simc_opts_t                            opts_o,
   input wire logic                                  result_read_o,
   input wire logic                                  reg_error_o
);
   logic [MON_WIDTH-1:0] x;
   always_comb begin
      x = '0;
      for (int w = 0; w < MON_WORDS; w++) x ^= mon_regs_i[w];
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   reset_clear_a: assert property ($fell(rst_i) |-> opts_o == '0 && !reg_error_o && !spi_dout_oe_o)
      else $error("state not clear after reset");
   oe_release_a: assert property (spi_i.cs_n [*6] |-> !spi_dout_oe_o)
      else $error("output driven while deselected");
   oe_drive_a: assert property (!spi_i.cs_n [*6] |-> spi_dout_oe_o)
      else $error("output not driven while selected");
   err_clear_a: assert property (!opts_o.register_checksum [*2] |-> !reg_error_o)
      else $error("error flag kept with checker off");
   err_cause_a: assert property ($rose(reg_error_o) |-> $past(opts_o.register_checksum))
      else $error("error flag without checker");
   err_set_a: assert property (opts_o.register_checksum [*3] ##0 x != $past(x) |-> ##[0:2] reg_error_o)
      else $error("monitored change not flagged");
   opts_quiet_a: assert property (spi_i.cs_n [*8] |-> $stable(opts_o))
      else $error("options changed without a frame");
   read_pulse_a: assert property (result_read_o |-> !$past(spi_i.cs_n) ##1 !result_read_o)
      else $error("bad result read pulse");
   cover property (result_read_o && opts_o.status_append);
   cover property ($rose(reg_error_o));
   cover property (result_read_o && opts_o.continuous_result_read);
endmodule : simc_ifopt_sva
bind simc_ifopt simc_ifopt_sva i_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_i(spi_i),
   .spi_dout_oe_o(spi_dout_oe_o), .mon_regs_i(mon_regs_i), .opts_o(opts_o),
   .result_read_o(result_read_o), .reg_error_o(reg_error_o));

// ==== sim/tb.sv ====
`timescale 1ns/100ps
module tb;
   import simc_pkg::*;
   logic                                sys_clk_i = 1'b0;
   logic                                rst_i     = 1'b1;
   logic                                ready_n_i = 1'b1;
   logic [23:0]                         result_i  = '0;
   logic [7:0]                          status_i  = '0;
   logic [MON_WORDS-1:0][MON_WIDTH-1:0] mon_q     = '0;
   simc_spi_in_t                        spi;
   simc_opts_t                          opts;
   logic                                dout, oe, rd_pulse, reg_err, tail;
   logic [55:0]                         rx;
   logic [31:0]                         e;
   logic [15:0]                         v;
   int                                  err_total = 0;
   int                                  checks    = 0;
   int                                  cyc       = 0;
   int                                  rd_cnt    = 0;

   simc_ifopt i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_i(spi), .spi_dout_o(dout),
      .spi_dout_oe_o(oe), .ready_n_i(ready_n_i), .result_i(result_i), .status_i(status_i),
      .mon_regs_i(mon_q), .opts_o(opts), .result_read_o(rd_pulse), .reg_error_o(reg_err));
   simc_host_model i_host (.sys_clk_i(sys_clk_i), .dout_i(dout), .spi_o(spi));

   initial forever #50 sys_clk_i = ~sys_clk_i;

   task automatic give_verdict();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // a hung frame must still reach the verdict
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         give_verdict();
      end
   end

   // result load pulses, held against the result reads issued
   always @(posedge sys_clk_i) begin
      if (rd_pulse === 1'b1) rd_cnt <= rd_cnt + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] d);
      i_host.xfer(24, {32'h0, 8'h02, d}, rx, tail);
   endtask : wr
   task automatic rd(input logic [5:0] a, input int n);
      i_host.xfer(8 + n, {48'h0, 2'b01, a} << n, rx, tail);
   endtask : rd
   function automatic logic [31:0] opt_exp(input logic [15:0] d);
      return {25'h0, d[12], d[11], d[10], d[8], d[7], d[6], d[5]};
   endfunction : opt_exp
   function automatic logic [31:0] xsum(input logic [MON_WORDS-1:0][MON_WIDTH-1:0] m);
      xsum = '0;
      for (int w = 0; w < MON_WORDS; w++) xsum ^= {8'h0, m[w]};
   endfunction : xsum

   initial begin
      void'($urandom(27696));
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      fork
         rd(ADDR_IFOPT, 16);
         begin
            repeat (20) @(posedge sys_clk_i);
            chk(32'(oe), 32'h1);
         end
      join
      chk(32'(oe), 32'h0);
      chk({16'h0, rx[15:0]}, 32'h0000);
      chk(32'(opts), 32'h0);
      // refused frames: cut write first, so a stuck frame would land in the next
      i_host.xfer(16, {40'h0, 8'h02, 8'hFF}, rx, tail);
      i_host.xfer(24, {32'h0, 8'h01, 16'h1DE0}, rx, tail);
      chk(32'(opts), 32'h0);
      rd(6'h01, 8);
      chk({24'h0, rx[7:0]}, 32'h0);
      $display("test reset done");
      // streaming kept off here, it changes framing
      for (int k = 0; k < 6; k++) begin
         v = (k == 0) ? 16'hFF7F : 16'($urandom) & 16'hFF7F;
         wr(v);
         rd(ADDR_IFOPT, 16);
         chk({16'h0, rx[15:0]}, {16'h0, v & IFOPT_WR_MASK});
         chk(32'(opts), opt_exp(v));
      end
      $display("test options done");
      for (int k = 0; k < 4; k++) begin
         wr({7'h0, k[1], 1'b0, k[0], 6'h0});
         result_i <= 24'($urandom);
         status_i <= 8'($urandom);
         @(posedge sys_clk_i);
         e = k[0] ? {result_i, status_i & 8'hBF} : {8'h0, result_i};
         ready_n_i <= ~e[0];
         @(posedge sys_clk_i);
         rd(ADDR_RESULT, k[0] ? 32 : 24);
         chk(k[0] ? rx[31:0] : {8'h0, rx[23:0]}, e);
         chk(32'(tail), 32'(k[1] ? e[0] : ready_n_i));
      end
      chk(32'(rd_cnt), 32'h4);
      $display("test result read done");
      wr(16'h0080);
      for (int k = 0; k < 2; k++) begin
         result_i <= 24'($urandom);
         @(posedge sys_clk_i);
         i_host.xfer(24, 56'h0, rx, tail);
         chk({8'h0, rx[23:0]}, {8'h0, result_i});
      end
      i_host.xfer(24, 56'h440000, rx, tail);
      rd(ADDR_IFOPT, 16);
      chk({16'h0, rx[15:0]}, 32'h0000);
      chk(32'(rd_cnt), 32'h7);
      $display("test continuous read done");
      rd(ADDR_CHECKSUM, 24);
      chk({8'h0, rx[23:0]}, 32'h0);
      for (int w = 0; w < MON_WORDS; w++) mon_q[w] <= 24'($urandom);
      @(posedge sys_clk_i);
      wr(16'h0020);
      rd(ADDR_CHECKSUM, 24);
      chk({8'h0, rx[23:0]}, xsum(mon_q));
      result_i <= ~result_i;
      status_i <= ~status_i;
      wr(16'h0060);
      chk(32'(reg_err), 32'h0);
      mon_q[1][0] <= ~mon_q[1][0];
      repeat (4) @(posedge sys_clk_i);
      chk(32'(reg_err), 32'h1);
      rd(ADDR_STATUS, 8);
      chk({24'h0, rx[7:0]}, {24'h0, status_i | 8'h40});
      wr(16'h0000);
      chk(32'(reg_err), 32'h0);
      mon_q[2] <= ~mon_q[2];
      @(posedge sys_clk_i);
      wr(16'h0020);
      repeat (4) @(posedge sys_clk_i);
      chk(32'(reg_err), 32'h0);
      $display("test checksum done");
      give_verdict();
   end
endmodule : tb

// ==== verilog/simc_checker.sv ====
`timescale 1ns/100ps
module simc_checker (
   // clock and reset
   input  wire logic                                                 sys_clk_i,
   input  wire logic                                                 rst_i,
   // control
   input  wire logic                                                 enable_i,
   input  wire logic [simc_pkg::MON_WORDS-1:0][simc_pkg::MON_WIDTH-1:0] mon_regs_i,
   // results
   output logic      [simc_pkg::MON_WIDTH-1:0]                       checksum_o,
   output logic                                                      reg_error_o
);
   import simc_pkg::*;

   logic [MON_WIDTH-1:0] sum;
   logic [MON_WIDTH-1:0] ref_q, ref_d;
   logic [MON_WIDTH-1:0] chk_q, chk_d;
   logic                 en_q,  en_d;
   logic                 err_q, err_d;

   always_comb begin
      sum = CHECKSUM_RESET;
      for (int i = 0; i < MON_WORDS; i++) begin
         sum = sum ^ mon_regs_i[i];
      end
      en_d  = enable_i;
      ref_d = ref_q;
      err_d = err_q;
      chk_d = CHECKSUM_RESET;
      if (!enable_i) begin
         err_d = 1'b0;
      end else if (!en_q) begin
         ref_d = sum;
         chk_d = sum;
      end else begin
         chk_d = sum;
         if (sum != ref_q) begin
            err_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ref_q <= CHECKSUM_RESET;
         chk_q <= CHECKSUM_RESET;
         en_q  <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ref_q <= ref_d;
         chk_q <= chk_d;
         en_q  <= en_d;
         err_q <= err_d;
      end
   end

   assign checksum_o  = chk_q;
   assign reg_error_o = err_q;

endmodule : simc_checker

// ==== verilog/simc_ifopt.sv ====
`timescale 1ns/100ps
module simc_ifopt (
   // clock and reset
   input  wire logic                                                 sys_clk_i,
   input  wire logic                                                 rst_i,
   // serial pins
   input  wire simc_pkg::simc_spi_in_t                               spi_i,
   output logic                                                      spi_dout_o,
   output logic                                                      spi_dout_oe_o,
   // converter side
   input  wire logic                                                 ready_n_i,
   input  wire logic [23:0]                                          result_i,
   input  wire logic [7:0]                                           status_i,
   input  wire logic [simc_pkg::MON_WORDS-1:0][simc_pkg::MON_WIDTH-1:0] mon_regs_i,
   // options and events
   output simc_pkg::simc_opts_t                                      opts_o,
   output logic                                                      result_read_o,
   output logic                                                      reg_error_o
);
   import simc_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_WR, ST_RD, ST_DONE, ST_HOLD} simc_state_t;

   // three-stage pin synchronisers and filtered levels
   logic [2:0]           cs_s_q, sclk_s_q, din_s_q;
   logic                 cs_f_q, cs_f_d, sclk_f_q, sclk_f_d, din_f_q, din_f_d;

   simc_state_t          st_q, st_d;
   logic [31:0]          sh_q, sh_d;
   logic [15:0]          rx_q, rx_d;
   logic [5:0]           cnt_q, cnt_d;
   logic [5:0]           len_q, len_d;
   logic [15:0]          ifm_q, ifm_d;
   logic                 dout_q, dout_d;
   logic                 oe_q, oe_d;
   logic                 rr_q, rr_d;

   logic                 cs_fall, cs_rise, sclk_fall, sclk_rise;
   logic [7:0]           rx_byte;
   logic [7:0]           stat_byte;
   logic [MON_WIDTH-1:0] checksum;
   logic                 reg_err;

   simc_checker u_checker (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .enable_i    (ifm_q[BIT_CHECKSUM_EN]),
      .mon_regs_i  (mon_regs_i),
      .checksum_o  (checksum),
      .reg_error_o (reg_err)
   );

   // change counts once stages two and three agree
   always_comb begin
      cs_f_d   = (cs_s_q[1]   == cs_s_q[2])   ? cs_s_q[2]   : cs_f_q;
      sclk_f_d = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_f_q;
      din_f_d  = (din_s_q[1]  == din_s_q[2])  ? din_s_q[2]  : din_f_q;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cs_s_q   <= 3'h7;
         sclk_s_q <= 3'h7;
         din_s_q  <= 3'h0;
         cs_f_q   <= 1'b1;
         sclk_f_q <= 1'b1;
         din_f_q  <= 1'b0;
      end else begin
         cs_s_q   <= {cs_s_q[1:0], spi_i.cs_n};
         sclk_s_q <= {sclk_s_q[1:0], spi_i.sclk};
         din_s_q  <= {din_s_q[1:0], spi_i.din};
         cs_f_q   <= cs_f_d;
         sclk_f_q <= sclk_f_d;
         din_f_q  <= din_f_d;
      end
   end

   always_comb begin
      cs_fall   = cs_f_q & ~cs_f_d;
      cs_rise   = ~cs_f_q & cs_f_d;
      sclk_fall = sclk_f_q & ~sclk_f_d;
      sclk_rise = ~sclk_f_q & sclk_f_d;
      rx_byte   = {rx_q[6:0], din_f_d};
      stat_byte = status_i;
      stat_byte[STAT_REG_ERR_BIT] = reg_err;

      st_d   = st_q;
      sh_d   = sh_q;
      rx_d   = rx_q;
      cnt_d  = cnt_q;
      len_d  = len_q;
      ifm_d  = ifm_q;
      dout_d = dout_q;
      oe_d   = oe_q;
      rr_d   = 1'b0;

      if (cs_rise) begin
         st_d   = ST_IDLE;
         oe_d   = 1'b0;
         dout_d = 1'b0;
      end else if (cs_fall) begin
         oe_d   = 1'b1;
         dout_d = ready_n_i;
         cnt_d  = 6'h00;
         if (ifm_q[BIT_CONT_READ]) begin
            st_d = ST_RD;
            rr_d = 1'b1;
            if (ifm_q[BIT_STAT_APPEND]) begin
               sh_d  = {result_i, stat_byte};
               len_d = LEN_WORD32;
            end else begin
               sh_d  = {result_i, 8'h00};
               len_d = LEN_WORD24;
            end
         end else begin
            st_d = ST_CMD;
         end
      end else begin
         if (st_q == ST_CMD || st_q == ST_DONE) begin
            dout_d = ready_n_i;
         end
         if (sclk_fall && st_q == ST_RD) begin
            dout_d = sh_q[31];
            sh_d   = {sh_q[30:0], 1'b0};
         end
         if (sclk_rise && st_q != ST_IDLE) begin
            rx_d  = {rx_q[14:0], din_f_d};
            cnt_d = cnt_q + 6'h01;
            case (st_q)
               ST_CMD: begin
                  if (cnt_q == LEN_CMD - 6'h01) begin
                     cnt_d = 6'h00;
                     if (rx_byte[CMD_RD_BIT]) begin
                        st_d = ST_RD;
                        case (rx_byte[5:0])
                           ADDR_STATUS: begin
                              sh_d  = {stat_byte, 24'h000000};
                              len_d = LEN_STATUS;
                           end
                           ADDR_IFOPT: begin
                              sh_d  = {ifm_q, 16'h0000};
                              len_d = LEN_IFOPT;
                           end
                           ADDR_CHECKSUM: begin
                              sh_d  = {checksum, 8'h00};
                              len_d = LEN_WORD24;
                           end
                           ADDR_RESULT: begin
                              rr_d = 1'b1;
                              if (ifm_q[BIT_STAT_APPEND]) begin
                                 sh_d  = {result_i, stat_byte};
                                 len_d = LEN_WORD32;
                              end else begin
                                 sh_d  = {result_i, 8'h00};
                                 len_d = LEN_WORD24;
                              end
                           end
                           default: begin
                              sh_d  = 32'h00000000;
                              len_d = LEN_STATUS;
                           end
                        endcase
                     end else if (rx_byte[5:0] == ADDR_IFOPT) begin
                        st_d = ST_WR;
                     end else begin
                        st_d = ST_DONE;
                     end
                  end
               end
               ST_WR: begin
                  if (cnt_q == LEN_IFOPT - 6'h01) begin
                     ifm_d = {rx_q[14:0], din_f_d} & IFOPT_WR_MASK;
                     st_d  = ST_DONE;
                  end
               end
               ST_RD: begin
                  if (ifm_q[BIT_CONT_READ] && cnt_q == LEN_CMD - 6'h01 && rx_byte == CMD_EXIT_CONT) begin
                     ifm_d[BIT_CONT_READ] = 1'b0;
                  end
                  if (cnt_q == len_q - 6'h01) begin
                     if (ifm_q[BIT_HOLD_LAST]) begin
                        st_d = ST_HOLD;
                     end else begin
                        st_d   = ST_DONE;
                        dout_d = ready_n_i;
                     end
                  end
               end
               default: begin
                  cnt_d = cnt_q;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_q   <= ST_IDLE;
         sh_q   <= 32'h00000000;
         rx_q   <= 16'h0000;
         cnt_q  <= 6'h00;
         len_q  <= 6'h00;
         ifm_q  <= IFOPT_RESET;
         dout_q <= 1'b0;
         oe_q   <= 1'b0;
         rr_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         sh_q   <= sh_d;
         rx_q   <= rx_d;
         cnt_q  <= cnt_d;
         len_q  <= len_d;
         ifm_q  <= ifm_d;
         dout_q <= dout_d;
         oe_q   <= oe_d;
         rr_q   <= rr_d;
      end
   end

   // options leave straight from the register bits
   assign opts_o.alternate_sync_enable  = ifm_q[BIT_ALTERNATE_SYNC_ENABLE];
   assign opts_o.output_drive_boost     = ifm_q[BIT_DRIVE_BOOST];
   assign opts_o.absorb_switch_delay    = ifm_q[BIT_ABSORB_DELAY];
   assign opts_o.hold_last_bit          = ifm_q[BIT_HOLD_LAST];
   assign opts_o.continuous_result_read = ifm_q[BIT_CONT_READ];
   assign opts_o.status_append          = ifm_q[BIT_STAT_APPEND];
   assign opts_o.register_checksum      = ifm_q[BIT_CHECKSUM_EN];
   assign spi_dout_o    = dout_q;
   assign spi_dout_oe_o = oe_q;
   assign result_read_o = rr_q;
   assign reg_error_o   = reg_err;

endmodule : simc_ifopt

// ==== verilog/simc_pkg.sv ====
package simc_pkg;

   // register addresses on the serial interface
   localparam logic [5:0]  ADDR_STATUS       = 6'h00;
   localparam logic [5:0]  ADDR_IFOPT        = 6'h02;
   localparam logic [5:0]  ADDR_CHECKSUM     = 6'h03;
   localparam logic [5:0]  ADDR_RESULT       = 6'h04;

   // interface_options_config field positions
   localparam int          BIT_ALTERNATE_SYNC_ENABLE      = 12;
   localparam int          BIT_DRIVE_BOOST   = 11;
   localparam int          BIT_ABSORB_DELAY  = 10;
   localparam int          BIT_HOLD_LAST     = 8;
   localparam int          BIT_CONT_READ     = 7;
   localparam int          BIT_STAT_APPEND   = 6;
   localparam int          BIT_CHECKSUM_EN   = 5;
   localparam logic [15:0] IFOPT_RESET       = 16'h0000;
   localparam logic [15:0] IFOPT_WR_MASK     = 16'h1DE0;

   // command byte layout
   localparam int          CMD_RD_BIT        = 6;
   localparam logic [7:0]  CMD_EXIT_CONT     = 8'h44;

   // status byte position of the register error flag
   localparam int          STAT_REG_ERR_BIT  = 6;

   // frame lengths in bits
   localparam logic [5:0]  LEN_CMD           = 6'h08;
   localparam logic [5:0]  LEN_STATUS        = 6'h08;
   localparam logic [5:0]  LEN_IFOPT         = 6'h10;
   localparam logic [5:0]  LEN_WORD24        = 6'h18;
   localparam logic [5:0]  LEN_WORD32        = 6'h20;

   // monitored register set
   localparam int          MON_WORDS         = 4;
   localparam int          MON_WIDTH         = 24;
   localparam logic [23:0] CHECKSUM_RESET    = 24'h000000;

   typedef struct packed {
      logic alternate_sync_enable;
      logic output_drive_boost;
      logic absorb_switch_delay;
      logic hold_last_bit;
      logic continuous_result_read;
      logic status_append;
      logic register_checksum;
   } simc_opts_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } simc_spi_in_t;

endpackage : simc_pkg
